// file: pkg/daab_regs.svh
`ifndef DAAB_REGS_SVH
`define DAAB_REGS_SVH
// ----------------------------------------
// Opcode patterns
// ----------------------------------------
`define DAAB_OP_ADD_LONG_HI 4'hd
`define DAAB_OP_ADD_LONG_LO 8'h02
`define DAAB_OP_IDX_ADD_HI 8'h7e
`define DAAB_OP_LOOP_JUMP 8'hfb
`define DAAB_OP_LOOP_JUMP_B7 1'b1
// ----------------------------------------
// Field positions and modify codes
// ----------------------------------------
`define DAAB_SHIFT_LSB 8
`define DAAB_MOD_NONE 3'h0
`define DAAB_MOD_DEC 3'h1
`define DAAB_MOD_INC 3'h2
`define DAAB_MOD_ADD_R0 3'h3
`define DAAB_MOD_SUB_R0 3'h4
`define DAAB_SUM_RESET 32'h0000_0000
`define DAAB_PC_RESET 16'h0000
`define DAAB_IDX_COUNT 8
`endif

// file: pkg/daab_pkg.sv
package daab_pkg;
    typedef enum logic [3:0] {
        DAAB_FETCH = 4'b0001,
        DAAB_ADD_WORD2 = 4'b0010,
        DAAB_JUMP_WORD2 = 4'b0100,
        DAAB_HALT = 4'b1000
    } daab_state_t;
endpackage : daab_pkg

// file: core/daab_idx_file.sv
`timescale 1ns/1ps
`include "daab_regs.svh"
module daab_idx_file
    import daab_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [2:0] wr_sel,
    input wire logic [15:0] wr_data,
    input wire logic [2:0] rd_sel,
    output logic [15:0] rd_data,
    output logic [15:0] idx0
);
    logic [15:0] mem_q [`DAAB_IDX_COUNT];
    logic [15:0] rd_q;
    // ----------------------------------------
    // Storage, one word per index register
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `DAAB_IDX_COUNT; gi++) begin : g_idx
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    mem_q[gi] <= 16'h0000;
                end else if (wr_en && wr_sel == 3'(gi)) begin
                    mem_q[gi] <= wr_data;
                end
            end
        end
    endgenerate
    // Registered read; write-through keeps same-cycle update visible
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rd_q <= 16'h0000;
        end else if (wr_en && wr_sel == rd_sel) begin
            rd_q <= wr_data;
        end else begin
            rd_q <= mem_q[rd_sel];
        end
    end
    assign rd_data = rd_q;
    assign idx0 = mem_q[0];
endmodule : daab_idx_file

// file: core/daab_core.sv
`timescale 1ns/1ps
`include "daab_regs.svh"
// Summary of operation
// - Long add: shifted second word into sum, PC+2
// - Short add into selected index register, PC+1
// - Short immediate always unsigned, low bits
// - Index adder separate; sum and flags untouched
// - Index modified whether or not jump taken
// - No modify field means decrement by one
// - Index registers wrap silently modulo 65536
module daab_core
    import daab_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [15:0] instr_word,
    input wire logic instr_valid,
    input wire logic [2:0] index_select,
    input wire logic sign_ext_mode,
    input wire logic saturate_mode,
    output logic instr_taken,
    output logic [15:0] pc,
    output logic [31:0] sum_register,
    output logic carry_flag,
    output logic overflow_flag,
    output logic [15:0] cur_index,
    output logic bad_opcode
);
    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic rst_s1_q, rst_s2_q;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    wire rst_n = rst_s2_q;

    // ----------------------------------------
    // State
    // ----------------------------------------
    daab_state_t state_q, state_d;
    logic [15:0] pc_q, pc_d;
    logic [31:0] sum_q, sum_d;
    logic c_q, c_d, ov_q, ov_d;
    logic [3:0] shift_q, shift_d;
    logic [2:0] mod_q, mod_d;
    logic taken_q, taken_d;
    logic bad_q, bad_d;
    logic idx_we;
    logic [15:0] idx_wdata, idx_rd, idx0;

    daab_idx_file u_idx (
        .mclk(mclk),
        .rst_n(rst_n),
        .wr_en(idx_we),
        .wr_sel(index_select),
        .wr_data(idx_wdata),
        .rd_sel(index_select),
        .rd_data(idx_rd),
        .idx0(idx0)
    );

    // ----------------------------------------
    // Long add datapath
    // ----------------------------------------
    // Carry is the unsigned carry out of bit 31; overflow is judged on a
    // sign-extended copy, so each comes from its own add (wide_u, wide_s) over the same operands.
    logic [32:0] ext_k, acc_ext, wide_u, wide_s;
    logic add_c, add_ov;
    logic [31:0] add_sum;
    always_comb begin
        ext_k = sign_ext_mode ? {{17{instr_word[15]}}, instr_word}
                              : {17'h0, instr_word};
        ext_k = ext_k << shift_q;
        acc_ext = {sum_q[31], sum_q};
        wide_u = {1'b0, sum_q} + {1'b0, ext_k[31:0]};
        wide_s = acc_ext + {ext_k[31], ext_k[31:0]};
        add_c = wide_u[32];
        add_ov = wide_s[32] != wide_s[31];
        if (add_ov && saturate_mode) begin
            add_sum = wide_s[32] ? 32'h8000_0000 : 32'h7fff_ffff;
        end else begin
            add_sum = wide_u[31:0];
        end
    end

    // ----------------------------------------
    // Loop step and branch test
    // ----------------------------------------
    // A step of idx0 can jump over zero; the wrap is silent by design.
    logic [15:0] step;
    logic idx_nonzero;
    always_comb begin
        case (mod_q)
            `DAAB_MOD_INC: step = 16'h0001;
            `DAAB_MOD_ADD_R0: step = idx0;
            `DAAB_MOD_SUB_R0: step = 16'h0000 - idx0;
            default: step = 16'hffff;
        endcase
        idx_nonzero = idx_rd != 16'h0000;
    end

    // ----------------------------------------
    // Opcode match
    // ----------------------------------------
    // Only read in FETCH, so a second word never reaches these matches.
    logic is_add_long, is_idx_add, is_loop_jump;
    always_comb begin
        is_add_long = instr_word[15:12] == `DAAB_OP_ADD_LONG_HI
                      && instr_word[7:0] == `DAAB_OP_ADD_LONG_LO;
        is_idx_add = instr_word[15:8] == `DAAB_OP_IDX_ADD_HI;
        is_loop_jump = instr_word[15:8] == `DAAB_OP_LOOP_JUMP && instr_word[7] == `DAAB_OP_LOOP_JUMP_B7;
    end

    // ----------------------------------------
    // Decode and execute
    // ----------------------------------------
    // The index read is registered, so a new instruction is taken only in FETCH;
    // the caller must hold index_select steady between instructions.
    always_comb begin
        state_d = state_q;
        pc_d = pc_q;
        sum_d = sum_q;
        c_d = c_q;
        ov_d = ov_q;
        shift_d = shift_q;
        mod_d = mod_q;
        taken_d = 1'b0;
        bad_d = 1'b0;
        idx_we = 1'b0;
        idx_wdata = idx_rd;
        case (state_q)
            DAAB_FETCH: begin
                if (instr_valid) begin
                    taken_d = 1'b1;
                    if (is_add_long) begin
                        shift_d = instr_word[`DAAB_SHIFT_LSB +: 4];
                        state_d = DAAB_ADD_WORD2;
                    end else if (is_idx_add) begin
                        idx_we = 1'b1;
                        idx_wdata = idx_rd + {8'h00, instr_word[7:0]};
                        pc_d = pc_q + 16'h0001;
                    end else if (is_loop_jump) begin
                        // Field zero means none given: decrement
                        mod_d = (instr_word[6:4] == `DAAB_MOD_NONE) ? `DAAB_MOD_DEC : instr_word[6:4];
                        state_d = DAAB_JUMP_WORD2;
                    end else begin
                        bad_d = 1'b1;
                        pc_d = pc_q + 16'h0001;
                    end
                end
            end
            DAAB_ADD_WORD2: begin
                if (instr_valid) begin
                    taken_d = 1'b1;
                    c_d = add_c;
                    ov_d = add_ov;
                    sum_d = add_sum;
                    pc_d = pc_q + 16'h0002;
                    state_d = DAAB_FETCH;
                end
            end
            DAAB_JUMP_WORD2: begin
                if (instr_valid) begin
                    taken_d = 1'b1;
                    pc_d = idx_nonzero ? instr_word : pc_q + 16'h0002;
                    idx_we = 1'b1;
                    idx_wdata = idx_rd + step;
                    state_d = DAAB_FETCH;
                end
            end
            default: begin
                state_d = DAAB_FETCH;
            end
        endcase
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    // Index words live in u_idx so that their read stays registered
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= DAAB_FETCH;
            pc_q <= `DAAB_PC_RESET;
            sum_q <= `DAAB_SUM_RESET;
            c_q <= 1'b0;
            ov_q <= 1'b0;
            shift_q <= 4'h0;
            mod_q <= 3'h0;
            taken_q <= 1'b0;
            bad_q <= 1'b0;
        end else begin
            state_q <= state_d;
            pc_q <= pc_d;
            sum_q <= sum_d;
            c_q <= c_d;
            ov_q <= ov_d;
            shift_q <= shift_d;
            mod_q <= mod_d;
            taken_q <= taken_d;
            bad_q <= bad_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign pc = pc_q;
    assign sum_register = sum_q;
    assign carry_flag = c_q;
    assign overflow_flag = ov_q;
    assign cur_index = idx_rd;
    assign instr_taken = taken_q;
    assign bad_opcode = bad_q;
endmodule : daab_core

// file: test/daab_checker.sv
`timescale 1ns/1ps
module daab_checker
    import daab_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [15:0] instr_word,
    input wire logic instr_valid,
    input wire logic sign_ext_mode,
    input wire logic saturate_mode,
    input wire logic [15:0] pc,
    input wire logic [31:0] sum_register,
    input wire logic carry_flag,
    input wire logic overflow_flag,
    input wire logic [15:0] cur_index
);
    // ----------------
    // Word tracking
    // ----------------
    logic [1:0] w2_q;
    logic [3:0] sh_q;
    logic [2:0] md_q;
    wire [31:0] ext = {{16{sign_ext_mode & instr_word[15]}}, instr_word} << sh_q;
    wire [32:0] tot = {1'b0, sum_register} + {1'b0, ext};
    wire ovf = sum_register[31] == ext[31] && tot[31] != ext[31];
    wire [31:0] satv = ext[31] ? 32'h8000_0000 : 32'h7fff_ffff;
    wire [15:0] k = {8'h00, instr_word[7:0]};
    wire op_k = instr_valid && w2_q == 2'h0 && instr_word[15:8] == 8'h7e;
    wire add2 = instr_valid && w2_q[0];
    wire jmp2 = instr_valid && w2_q[1];
    // Opcode fields are latched only on first words so a constant never disturbs them
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            w2_q <= 2'h0;
        end else if (instr_valid) begin
            w2_q <= (w2_q != 2'h0) ? 2'h0 : {instr_word[15:7] == 9'h1f7, instr_word[15:12] == 4'hd && instr_word[7:0] == 8'h02};
        end
    end
    always_ff @(posedge mclk) begin
        if (instr_valid && w2_q == 2'h0) begin
            sh_q <= instr_word[11:8];
            md_q <= instr_word[6:4];
        end
    end
    // ----------------
    // Properties
    // ----------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    sequence s_add2; add2 && !(saturate_mode && ovf); endsequence
    sequence s_jmp2; jmp2; endsequence
    property p_add_pc; add2 |=> pc == $past(pc) + 16'h2; endproperty
    a_add_pc: assert property (p_add_pc) else $error("long add pc step wrong");
    property p_add_sum; s_add2 |=> {carry_flag, sum_register} == $past(tot); endproperty
    a_add_sum: assert property (p_add_sum) else $error("long add sum or carry wrong");
    property p_add_ovf; add2 |=> overflow_flag == $past(ovf); endproperty
    a_add_ovf: assert property (p_add_ovf) else $error("overflow flag wrong");
    property p_add_sat; add2 && saturate_mode && ovf |=> sum_register == $past(satv); endproperty
    a_add_sat: assert property (p_add_sat) else $error("saturation wrong");
    property p_k_pc;
        op_k |=> pc == $past(pc) + 16'h1 && $stable(sum_register) && $stable(carry_flag) && $stable(overflow_flag);
    endproperty
    a_k_pc: assert property (p_k_pc) else $error("index add touched pc or sum");
    property p_k_val; op_k |=> ##1 cur_index == $past(cur_index, 2) + $past(k, 2); endproperty
    a_k_val: assert property (p_k_val) else $error("index add value wrong");
    property p_jmp_tk; s_jmp2 ##0 cur_index != 16'h0 |=> pc == $past(instr_word); endproperty
    a_jmp_tk: assert property (p_jmp_tk) else $error("loop jump not taken");
    property p_jmp_nt; s_jmp2 ##0 cur_index == 16'h0 |=> pc == $past(pc) + 16'h2; endproperty
    a_jmp_nt: assert property (p_jmp_nt) else $error("loop jump fall through wrong");
    property p_jmp_dec; s_jmp2 ##0 md_q < 3'h2 |=> ##1 cur_index == $past(cur_index, 2) - 16'h1; endproperty
    a_jmp_dec: assert property (p_jmp_dec) else $error("loop index not decremented");
endmodule : daab_checker

// file: test/test_dsp_add_and_branch_ops.sv
`timescale 1ns/1ps
module test_dsp_add_and_branch_ops;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    logic instr_valid = 1'b0;
    logic [2:0] index_select = 3'h3;
    logic sign_ext_mode = 1'b0;
    logic saturate_mode = 1'b0;
    logic [15:0] pc, cur_index;
    logic [31:0] sum_register;
    logic carry_flag, overflow_flag;
    logic instr_taken, bad_opcode;
    int err_count = 0;
    int n_compared = 0;
    int cyc = 0;
    daab_core uut (.mclk(mclk), .rstn(rstn), .instr_word(instr_word), .instr_valid(instr_valid),
        .index_select(index_select), .sign_ext_mode(sign_ext_mode), .saturate_mode(saturate_mode),
        .instr_taken(instr_taken), .pc(pc), .sum_register(sum_register), .carry_flag(carry_flag),
        .overflow_flag(overflow_flag), .cur_index(cur_index), .bad_opcode(bad_opcode));
    initial begin
        forever #2.5 mclk = ~mclk;
    end
    // ----------------
    // Helpers
    // ----------------
    task wr(input logic [15:0] w);
        instr_word = w;
        instr_valid = 1'b1;
        @(posedge mclk);
        #1;
    endtask : wr
    task idl(input int n);
        instr_valid = 1'b0;
        repeat (n) @(posedge mclk);
        #1;
    endtask : idl
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task stop_test;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : stop_test
    // ----------------
    // Scenarios
    // ----------------
    task t_add;
        wr(16'hd502); wr(16'h8001); idl(2);
        chk("sum", 32'h0010_0020, sum_register);
        sign_ext_mode = 1'b1;
        wr(16'hd002); wr(16'hffff); idl(2);
        chk("sum", 32'h0010_001f, sum_register);
        chk("carry", 32'h1, {31'h0, carry_flag});
        wr(16'hdf02); wr(16'h0001); idl(2);
        chk("sum", 32'h0010_801f, sum_register);
        chk("pc", 32'h6, {16'h0, pc});
        $display("long add done");
    endtask : t_add
    task t_sat;
        saturate_mode = 1'b1;
        wr(16'hdf02); wr(16'h7fff); wr(16'hdf02); wr(16'h7fff); idl(2);
        chk("sum", 32'h7fff_ffff, sum_register);
        chk("ovf", 32'h1, {31'h0, overflow_flag});
        $display("saturation done");
    endtask : t_sat
    task t_idx;
        wr(16'h7eff); idl(2); wr(16'h7e80); idl(2);
        chk("index", 32'h017f, {16'h0, cur_index});
        chk("pc", 32'hc, {16'h0, pc});
        chk("sum", 32'h7fff_ffff, sum_register);
        chk("ovf", 32'h1, {31'h0, overflow_flag});
        $display("index add done");
    endtask : t_idx
    task t_jmp;
        wr(16'hfb80); wr(16'h0100); idl(2);
        chk("pc", 32'h0100, {16'h0, pc});
        chk("index", 32'h017e, {16'h0, cur_index});
        index_select = 3'h5;
        idl(2);
        wr(16'hfb80); wr(16'h0200); idl(2);
        chk("pc", 32'h0102, {16'h0, pc});
        chk("index", 32'hffff, {16'h0, cur_index});
        wr(16'hfba0); wr(16'h0040); idl(2);
        chk("pc", 32'h0040, {16'h0, pc});
        chk("index", 32'h0, {16'h0, cur_index});
        $display("loop jump done");
    endtask : t_jmp
    task t_misc;
        wr(16'h7d05);
        chk("bad", 32'h1, {31'h0, bad_opcode});
        chk("taken", 32'h1, {31'h0, instr_taken});
        idl(1);
        chk("bad", 32'h0, {31'h0, bad_opcode});
        chk("taken", 32'h0, {31'h0, instr_taken});
        chk("index", 32'h0, {16'h0, cur_index});
        index_select = 3'h0;
        idl(1);
        wr(16'h7e03); idl(2);
        chk("index", 32'h3, {16'h0, cur_index});
        index_select = 3'h5;
        idl(1);
        wr(16'hfbb0); wr(16'h0300); idl(2);
        chk("pc", 32'h0044, {16'h0, pc});
        chk("index", 32'h3, {16'h0, cur_index});
        wr(16'hfbc0); wr(16'h0500); idl(2);
        chk("pc", 32'h0500, {16'h0, pc});
        chk("index", 32'h0, {16'h0, cur_index});
        repeat (4) begin
            wr(16'hdf02);
            wr(16'h8000);
        end
        idl(2);
        chk("sum", 32'h8000_0000, sum_register);
        chk("ovf", 32'h1, {31'h0, overflow_flag});
        chk("pc", 32'h0508, {16'h0, pc});
        $display("decode and step modes done");
    endtask : t_misc
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 2000) begin
            err_count++;
            stop_test;
        end
    end
    initial begin
        repeat (20) @(posedge mclk);
        #1;
        rstn = 1'b1;
        idl(6);
        t_add;
        t_sat;
        t_idx;
        t_jmp;
        t_misc;
        stop_test;
    end
endmodule : test_dsp_add_and_branch_ops
bind daab_core daab_checker chk_i (.mclk(mclk), .rstn(rstn), .instr_word(instr_word), .instr_valid(instr_valid),
    .sign_ext_mode(sign_ext_mode), .saturate_mode(saturate_mode), .pc(pc), .sum_register(sum_register),
    .carry_flag(carry_flag), .overflow_flag(overflow_flag), .cur_index(cur_index));
